// File: core/isda_core.sv
// Serial engine status flags, data shift register, bus wait and own-address match
`timescale 1ns/1ps
module isda_core (
  input wire logic ref_clk_i,
  input wire logic rst_n_i,
  input isda_pkg::isda_sfr_req_t sfr_req_i,
  output logic [7:0] sfr_rdata_o,
  input wire logic scl_i,
  input wire logic sda_i,
  output logic scl_o,
  output logic scl_oe_o,
  output logic sda_o,
  output logic sda_oe_o,
  input wire logic start_request_i,
  input wire logic stop_request_bit_i,
  input wire logic ack_enable_i,
  input wire logic scl_tick_i,
  output logic intr_o,
  output logic tx_mode_o,
  output logic addr_match_set_o,
  output logic stop_done_o
);

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  typedef struct packed {
    isda_pkg::isda_fsm_t fsm;
    isda_pkg::isda_status_t stat;
    logic [7:0] data;
    logic [7:0] adr;
    logic [3:0] bitcnt;
    logic master;
    logic mhigh;
    logic selected;
    logic first;
    logic [7:0] rdata;
    logic scl_oe;
    logic sda_oe;
    logic addr_match;
    logic stop_done;
  } isda_core_state_t;

  isda_core_state_t st_reg;
  isda_core_state_t st_next;
  isda_pkg::isda_line_ev_t ev;

  isda_line_mon u_line_mon (
    .ref_clk_i(ref_clk_i),
    .rst_n_i(rst_n_i),
    .scl_i(scl_i),
    .sda_i(sda_i),
    .ev_o(ev)
  );

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  always_comb
  begin
    logic [7:0] sh;
    logic [3:0] cnt;
    logic wr_status;
    logic wr_data;
    logic rd_data;
    sh = {st_reg.data[6:0], ev.sda};
    cnt = st_reg.bitcnt + 4'h1;
    wr_status = sfr_req_i.wr && (sfr_req_i.addr == isda_pkg::LINK_STATUS_OFS);
    wr_data = sfr_req_i.wr && (sfr_req_i.addr == isda_pkg::DATA_SHIFT_OFS);
    rd_data = sfr_req_i.rd && (sfr_req_i.addr == isda_pkg::DATA_SHIFT_OFS);
    st_next = st_reg;
    st_next.addr_match = 1'b0;
    st_next.stop_done = 1'b0;

    // Only the interrupt flag takes a write; engine sets below win
    if (wr_status)
    begin
      st_next.stat.intr = sfr_req_i.wdata[isda_pkg::INTR_BIT];
    end
    if (sfr_req_i.wr && (sfr_req_i.addr == isda_pkg::OWN_ADDR_OFS))
    begin
      st_next.adr = {sfr_req_i.wdata[7:1], 1'b0};
    end
    // Software may overwrite the shifter at any time; it is its job not to
    if (wr_data)
    begin
      st_next.data = sfr_req_i.wdata;
    end

    // ----------------------------------------------------------------
    // Bus conditions seen by every role
    // ----------------------------------------------------------------
    if (ev.start)
    begin
      st_next.stat.bus_in_use_flag = 1'b1;
      st_next.stat.stop_seen = 1'b0;
      st_next.stat.gen_call = 1'b0;
    end
    if (ev.stop)
    begin
      st_next.stat.bus_in_use_flag = 1'b0;
      st_next.stat.stop_seen = 1'b1;
      st_next.stat.gen_call = 1'b0;
    end

    unique case (st_reg.fsm)
      isda_pkg::ST_IDLE:
      begin
        if (start_request_i && !st_reg.stat.bus_in_use_flag)
        begin
          // Address byte must already sit in the shifter
          st_next.fsm = isda_pkg::ST_M_START;
          st_next.master = 1'b1;
          st_next.sda_oe = 1'b1;
          st_next.stat.slave_role_flag = 1'b0;
          st_next.stat.arbitration_lost_flag = 1'b0;
        end
      end

      isda_pkg::ST_SLAVE:
      begin
        if (ev.scl_fall)
        begin
          if (st_reg.bitcnt < isda_pkg::ACK_BIT)
          begin
            st_next.sda_oe = st_reg.stat.tx_mode & ~st_reg.data[7];
          end
          else if (st_reg.bitcnt == isda_pkg::ACK_BIT)
          begin
            st_next.sda_oe = (st_reg.first | ~st_reg.stat.tx_mode) & ack_enable_i;
          end
          else
          begin
            st_next.sda_oe = 1'b0;
            st_next.scl_oe = 1'b1;
            st_next.stat.intr = 1'b1;
            st_next.first = 1'b0;
            st_next.fsm = isda_pkg::ST_WAIT;
          end
        end
        if (ev.scl_rise)
        begin
          st_next.bitcnt = cnt;
          if (st_reg.bitcnt < isda_pkg::ACK_BIT)
          begin
            st_next.data = sh;
            if (st_reg.first && st_reg.bitcnt == isda_pkg::LAST_DATA_BIT)
            begin
              // Address byte complete: compare own address
              if (ack_enable_i && sh[7:1] == st_reg.adr[7:1])
              begin
                st_next.selected = 1'b1;
                st_next.addr_match = 1'b1;
                st_next.stat.intr = 1'b1;
                st_next.stat.tx_mode = sh[0];
              end
              else if (ack_enable_i && sh == 8'h00)
              begin
                st_next.selected = 1'b1;
                st_next.stat.gen_call = 1'b1;
                st_next.stat.intr = 1'b1;
                st_next.stat.tx_mode = 1'b0;
              end
              else
              begin
                st_next.fsm = isda_pkg::ST_IDLE;
              end
            end
          end
          else if (st_reg.bitcnt == isda_pkg::ACK_BIT && st_reg.stat.tx_mode && !st_reg.first)
          begin
            st_next.stat.nack_seen_flag = ev.sda;
          end
        end
      end

      isda_pkg::ST_WAIT:
      begin
        if (st_reg.master && stop_request_bit_i)
        begin
          // Stop is only ever issued on request
          st_next.fsm = isda_pkg::ST_M_STOP;
          st_next.sda_oe = 1'b1;
        end
        else if ((st_reg.stat.tx_mode && wr_data) || (!st_reg.stat.tx_mode && rd_data))
        begin
          st_next.bitcnt = 4'h0;
          st_next.sda_oe = st_reg.stat.tx_mode & ~sfr_req_i.wdata[7];
          if (st_reg.master)
          begin
            // The master drops its hold at the next bit-rate tick
            st_next.fsm = isda_pkg::ST_M_BIT;
            st_next.mhigh = 1'b0;
          end
          else
          begin
            st_next.scl_oe = 1'b0;
            st_next.fsm = isda_pkg::ST_SLAVE;
          end
        end
      end

      isda_pkg::ST_M_START:
      begin
        if (scl_tick_i)
        begin
          st_next.scl_oe = 1'b1;
          st_next.stat.tx_mode = 1'b1;
          st_next.first = 1'b1;
          st_next.bitcnt = 4'h0;
          st_next.mhigh = 1'b0;
          st_next.sda_oe = ~st_reg.data[7];
          st_next.fsm = isda_pkg::ST_M_BIT;
        end
      end

      isda_pkg::ST_M_BIT:
      begin
        if (scl_tick_i && !st_reg.mhigh)
        begin
          st_next.scl_oe = 1'b0;
          st_next.mhigh = 1'b1;
        end
        else if (scl_tick_i && ev.scl)
        begin
          // A low line where we released it means another master won
          if (st_reg.stat.tx_mode && st_reg.bitcnt < isda_pkg::ACK_BIT
              && !st_reg.sda_oe && !ev.sda)
          begin
            st_next.stat.arbitration_lost_flag = 1'b1;
            st_next.stat.intr = 1'b1;
            st_next.master = 1'b0;
            st_next.scl_oe = 1'b0;
            st_next.sda_oe = 1'b0;
            st_next.fsm = isda_pkg::ST_IDLE;
          end
          else
          begin
            st_next.scl_oe = 1'b1;
            st_next.mhigh = 1'b0;
            st_next.bitcnt = cnt;
            if (st_reg.bitcnt < isda_pkg::ACK_BIT)
            begin
              st_next.data = sh;
            end
            else if (st_reg.stat.tx_mode)
            begin
              st_next.stat.nack_seen_flag = ev.sda;
            end
            if (cnt < isda_pkg::ACK_BIT)
            begin
              st_next.sda_oe = st_reg.stat.tx_mode & ~sh[7];
            end
            else if (cnt == isda_pkg::ACK_BIT)
            begin
              st_next.sda_oe = ~st_reg.stat.tx_mode & ack_enable_i;
            end
            else
            begin
              // Hold the clock low with the flag raised; a nack just waits
              st_next.sda_oe = 1'b0;
              st_next.stat.intr = 1'b1;
              st_next.fsm = isda_pkg::ST_WAIT;
              st_next.first = 1'b0;
              if (st_reg.first)
              begin
                st_next.stat.tx_mode = ~st_reg.data[0];
              end
            end
          end
        end
      end

      isda_pkg::ST_M_STOP:
      begin
        if (scl_tick_i && st_reg.scl_oe)
        begin
          st_next.scl_oe = 1'b0;
        end
        else if (scl_tick_i && ev.scl)
        begin
          st_next.sda_oe = 1'b0;
          st_next.master = 1'b0;
          st_next.stop_done = 1'b1;
          st_next.fsm = isda_pkg::ST_IDLE;
        end
      end
    endcase

    // ----------------------------------------------------------------
    // Start and stop override any slave activity
    // ----------------------------------------------------------------
    if (!st_reg.master && ev.start)
    begin
      // Own address is consulted only in this role
      st_next.fsm = isda_pkg::ST_SLAVE;
      st_next.stat.slave_role_flag = 1'b1;
      st_next.stat.tx_mode = 1'b0;
      st_next.bitcnt = 4'h0;
      st_next.first = 1'b1;
      st_next.selected = 1'b0;
      st_next.scl_oe = 1'b0;
      st_next.sda_oe = 1'b0;
    end
    else if (!st_reg.master && ev.stop)
    begin
      if (st_reg.selected)
      begin
        st_next.stat.intr = 1'b1;
      end
      st_next.fsm = isda_pkg::ST_IDLE;
      st_next.stat.slave_role_flag = 1'b0;
      st_next.selected = 1'b0;
      st_next.scl_oe = 1'b0;
      st_next.sda_oe = 1'b0;
    end

    // ----------------------------------------------------------------
    // Read data, one cycle after the strobe
    // ----------------------------------------------------------------
    unique case (sfr_req_i.addr)
      isda_pkg::LINK_STATUS_OFS: st_next.rdata = st_reg.stat;
      isda_pkg::DATA_SHIFT_OFS: st_next.rdata = st_reg.data;
      isda_pkg::OWN_ADDR_OFS: st_next.rdata = st_reg.adr;
      default: st_next.rdata = isda_pkg::READ_UNMAPPED;
    endcase
  end

  always_ff @(posedge ref_clk_i)
  begin
    if (!rst_n_i)
    begin
      st_reg <= '0;
      st_reg.fsm <= isda_pkg::ST_IDLE;
      st_reg.stat <= isda_pkg::LINK_STATUS_RST;
      st_reg.data <= isda_pkg::DATA_SHIFT_RST;
      st_reg.adr <= isda_pkg::OWN_ADDR_RST;
    end
    else
    begin
      st_reg <= st_next;
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  // Open-drain lines only ever drive low
  assign scl_o = 1'b0;
  assign sda_o = 1'b0;
  assign scl_oe_o = st_reg.scl_oe;
  assign sda_oe_o = st_reg.sda_oe;
  assign sfr_rdata_o = st_reg.rdata;
  assign intr_o = st_reg.stat.intr;
  assign tx_mode_o = st_reg.stat.tx_mode;
  assign addr_match_set_o = st_reg.addr_match;
  assign stop_done_o = st_reg.stop_done;

endmodule

// File: core/isda_pkg.sv
// Package of shared constants and types for the serial status, data and address block
package isda_pkg;

  // ----------------------------------------------------------------
  // Register offsets on the special function register port
  // ----------------------------------------------------------------
  localparam logic [7:0] LINK_STATUS_OFS = 8'hdd;
  localparam logic [7:0] DATA_SHIFT_OFS = 8'hde;
  localparam logic [7:0] OWN_ADDR_OFS = 8'hdf;

  // ----------------------------------------------------------------
  // Reset values and field positions
  // ----------------------------------------------------------------
  localparam logic [7:0] LINK_STATUS_RST = 8'h00;
  localparam logic [7:0] DATA_SHIFT_RST = 8'h00;
  localparam logic [7:0] OWN_ADDR_RST = 8'h00;
  localparam logic [7:0] READ_UNMAPPED = 8'h00;
  localparam int unsigned INTR_BIT = 5;
  localparam int unsigned ADDR_MSB = 7;
  localparam int unsigned ADDR_LSB = 1;

  // ----------------------------------------------------------------
  // Byte framing counts
  // ----------------------------------------------------------------
  localparam logic [3:0] LAST_DATA_BIT = 4'h7;
  localparam logic [3:0] ACK_BIT = 4'h8;
  localparam logic [3:0] BYTE_DONE = 4'h9;

  // ----------------------------------------------------------------
  // Carriers
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [7:0] addr;
    logic wr;
    logic rd;
    logic [7:0] wdata;
  } isda_sfr_req_t;

  // Bit order matches the status register, bit 7 first
  typedef struct packed {
    logic gen_call;
    logic stop_seen;
    logic intr;
    logic tx_mode;
    logic bus_in_use_flag;
    logic arbitration_lost_flag;
    logic nack_seen_flag;
    logic slave_role_flag;
  } isda_status_t;

  typedef struct packed {
    logic scl;
    logic sda;
    logic scl_rise;
    logic scl_fall;
    logic start;
    logic stop;
  } isda_line_ev_t;

  typedef enum logic [2:0] {
    ST_IDLE,
    ST_SLAVE,
    ST_WAIT,
    ST_M_START,
    ST_M_BIT,
    ST_M_STOP
  } isda_fsm_t;

endpackage

// File: core/isda_line_mon.sv
// Bus line monitor: edges of the clock line and start and stop conditions
`timescale 1ns/1ps
module isda_line_mon (
  input wire logic ref_clk_i,
  input wire logic rst_n_i,
  input wire logic scl_i,
  input wire logic sda_i,
  output isda_pkg::isda_line_ev_t ev_o
);

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  typedef struct packed {
    logic scl_prev;
    logic sda_prev;
    isda_pkg::isda_line_ev_t ev;
  } isda_mon_state_t;

  isda_mon_state_t mon_reg;
  isda_mon_state_t mon_next;

  always_comb
  begin
    mon_next = mon_reg;
    mon_next.scl_prev = scl_i;
    mon_next.sda_prev = sda_i;
    mon_next.ev.scl = scl_i;
    mon_next.ev.sda = sda_i;
    mon_next.ev.scl_rise = scl_i & ~mon_reg.scl_prev;
    mon_next.ev.scl_fall = ~scl_i & mon_reg.scl_prev;
    // Data edges while the clock stays high frame a transfer
    mon_next.ev.start = scl_i & mon_reg.scl_prev & mon_reg.sda_prev & ~sda_i;
    mon_next.ev.stop = scl_i & mon_reg.scl_prev & ~mon_reg.sda_prev & sda_i;
  end

  always_ff @(posedge ref_clk_i)
  begin
    if (!rst_n_i)
    begin
      // Idle bus lines are high
      mon_reg <= '{scl_prev: 1'b1, sda_prev: 1'b1, ev: '{scl: 1'b1, sda: 1'b1, default: 1'b0}};
    end
    else
    begin
      mon_reg <= mon_next;
    end
  end

  assign ev_o = mon_reg.ev;

endmodule

// File: bench/isda_core_asserts.sv
// Port assertions for the serial status, data and address block
`timescale 1ns/1ps
module isda_core_asserts (
  input wire logic ref_clk_i,
  input wire logic rst_n_i,
  input isda_pkg::isda_sfr_req_t sfr_req_i,
  input wire logic [7:0] sfr_rdata_o,
  input wire logic scl_oe_o,
  input wire logic scl_tick_i,
  input wire logic stop_request_bit_i,
  input wire logic intr_o,
  input wire logic tx_mode_o,
  input wire logic addr_match_set_o,
  input wire logic stop_done_o
);
  default clocking @(posedge ref_clk_i); endclocking
  default disable iff (!rst_n_i);
  logic dwr, drd, swr;
  assign dwr = sfr_req_i.wr && sfr_req_i.addr == isda_pkg::DATA_SHIFT_OFS;
  assign drd = sfr_req_i.rd && sfr_req_i.addr == isda_pkg::DATA_SHIFT_OFS;
  assign swr = sfr_req_i.wr && sfr_req_i.addr == isda_pkg::LINK_STATUS_OFS;
  // ------------------------------------------------------------
  // Assertions
  // ------------------------------------------------------------
  property p_match_intr; addr_match_set_o |-> ##[0:3] intr_o; endproperty
  a_match_intr: assert property (p_match_intr)
    else $error("match without intr");
  property p_match_pulse; addr_match_set_o |=> !addr_match_set_o; endproperty
  a_match_pulse: assert property (p_match_pulse)
    else $error("match pulse too long");
  property p_tx_release; scl_oe_o && tx_mode_o && dwr |=> !scl_oe_o; endproperty
  a_tx_release: assert property (p_tx_release)
    else $error("write kept clock held");
  property p_rx_release; scl_oe_o && !tx_mode_o && drd |=> !scl_oe_o; endproperty
  a_rx_release: assert property (p_rx_release)
    else $error("read kept clock held");
  // Only a data access or a stop may end the wait
  property p_hold;
    scl_oe_o && !dwr && !drd && !stop_request_bit_i && !scl_tick_i |=> scl_oe_o;
  endproperty
  a_hold: assert property (p_hold)
    else $error("clock hold dropped");
  property p_intr_keep; intr_o && !swr |=> intr_o; endproperty
  a_intr_keep: assert property (p_intr_keep)
    else $error("intr cleared by itself");
  property p_intr_clear;
    swr && !sfr_req_i.wdata[isda_pkg::INTR_BIT] && scl_oe_o |=> !intr_o;
  endproperty
  a_intr_clear: assert property (p_intr_clear)
    else $error("intr not cleared");
  property p_addr_bit0;
    sfr_req_i.rd && sfr_req_i.addr == isda_pkg::OWN_ADDR_OFS |=> !sfr_rdata_o[0];
  endproperty
  a_addr_bit0: assert property (p_addr_bit0)
    else $error("own address bit 0 set");
  property p_no_auto_stop; stop_done_o |-> stop_request_bit_i; endproperty
  a_no_auto_stop: assert property (p_no_auto_stop)
    else $error("stop without request");
endmodule
bind isda_core isda_core_asserts i_chk (.ref_clk_i(ref_clk_i), .rst_n_i(rst_n_i),
  .sfr_req_i(sfr_req_i), .sfr_rdata_o(sfr_rdata_o), .scl_oe_o(scl_oe_o),
  .scl_tick_i(scl_tick_i), .stop_request_bit_i(stop_request_bit_i), .intr_o(intr_o),
  .tx_mode_o(tx_mode_o), .addr_match_set_o(addr_match_set_o), .stop_done_o(stop_done_o));

// File: bench/isda_bus_model.sv
// Outside bus master model, pulling both lines open drain
`timescale 1ns/1ps
module isda_bus_model #(
  parameter int HALF = 8
) (
  input wire logic ref_clk_i,
  input wire logic scl_i,
  input wire logic sda_i,
  output logic scl_pull_o = 1'b0,
  output logic sda_pull_o = 1'b0
);
  // Slaves may stretch the clock, so wait for the line, bounded
  task automatic rise();
    scl_pull_o <= 1'b0;
    for (int n = 0; n < 4000 && scl_i !== 1'b1; n++) @(posedge ref_clk_i);
    repeat (HALF) @(posedge ref_clk_i);
  endtask
  task automatic start_c();
    @(posedge ref_clk_i);
    sda_pull_o <= 1'b1;
    repeat (HALF) @(posedge ref_clk_i);
    scl_pull_o <= 1'b1;
    repeat (HALF) @(posedge ref_clk_i);
  endtask
  task automatic stop_c();
    @(posedge ref_clk_i);
    sda_pull_o <= 1'b1;
    repeat (HALF) @(posedge ref_clk_i);
    rise();
    sda_pull_o <= 1'b0;
    repeat (HALF) @(posedge ref_clk_i);
  endtask
  // Nine bits, eight of data then the acknowledge; a 1 releases the data line
  task automatic byte_x(input logic [8:0] d, output logic [8:0] q);
    @(posedge ref_clk_i);
    for (int i = 8; i >= 0; i--)
    begin
      sda_pull_o <= ~d[i];
      repeat (HALF) @(posedge ref_clk_i);
      rise();
      q[i] = sda_i;
      scl_pull_o <= 1'b1;
      @(posedge ref_clk_i);
    end
  endtask
endmodule

// File: bench/i2c_status_data_address_tb.sv
// Testbench for the serial status, data and address block
`timescale 1ns/1ps
module i2c_status_data_address_tb;
  // Row: write flag, offset, write data, expected read
  localparam logic [24:0] ROWS [8] = '{25'h0dd0000, 25'h0de0000, 25'h0df0000,
    25'h0100000, 25'h1de3c3c, 25'h1dfa5a4, 25'h1ddff20, 25'h1dd0000};
  localparam logic [7:0] TXB [2] = '{8'hc3, 8'h5a};
  localparam logic [7:0] ST = isda_pkg::LINK_STATUS_OFS;
  localparam logic [7:0] DT = isda_pkg::DATA_SHIFT_OFS;
  localparam logic [7:0] AD = isda_pkg::OWN_ADDR_OFS;
  logic ref_clk_i = 1'b0;
  logic rst_n_i = 1'b0;
  logic ack_en = 1'b1;
  isda_pkg::isda_sfr_req_t req = '0;
  logic [7:0] rdata, v;
  logic [8:0] q;
  logic scl_oe, sda_oe, intr, txm, amatch, m_scl, m_sda;
  logic match_seen = 1'b0;
  logic done_seen = 1'b0;
  logic start_req = 1'b0;
  logic stop_req = 1'b0;
  logic tick = 1'b0;
  logic sdone;
  logic [2:0] tcnt = 3'h0;
  logic [8:0] cap = 9'h000;
  int error_cnt = 0;
  int cmp_count = 0;
  wire scl_ln = !(scl_oe === 1'b1 || m_scl);
  wire sda_ln = !(sda_oe === 1'b1 || m_sda);
  always #2.5 ref_clk_i = ~ref_clk_i;
  always @(posedge ref_clk_i)
  begin
    if (amatch === 1'b1) match_seen <= 1'b1;
    if (sdone === 1'b1) done_seen <= 1'b1;
    // Free-running bit-rate tick, one master half-bit per eight clocks
    tcnt <= tcnt + 3'h1;
    tick <= (tcnt == 3'h0);
  end
  // Bits as any receiver on the bus sees them, at each clock-line rise
  always @(posedge scl_ln) cap <= {cap[7:0], sda_ln};
  isda_core i_dut (
    .ref_clk_i(ref_clk_i), .rst_n_i(rst_n_i), .sfr_req_i(req), .sfr_rdata_o(rdata),
    .scl_i(scl_ln), .sda_i(sda_ln), .scl_o(), .scl_oe_o(scl_oe), .sda_o(),
    .sda_oe_o(sda_oe), .start_request_i(start_req), .stop_request_bit_i(stop_req),
    .ack_enable_i(ack_en), .scl_tick_i(tick), .intr_o(intr), .tx_mode_o(txm),
    .addr_match_set_o(amatch), .stop_done_o(sdone)
  );
  isda_bus_model i_mst (
    .ref_clk_i(ref_clk_i), .scl_i(scl_ln), .sda_i(sda_ln), .scl_pull_o(m_scl),
    .sda_pull_o(m_sda)
  );
  // ------------------------------------------------------------
  // Helpers
  // ------------------------------------------------------------
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    cmp_count++;
    if (got !== exp)
    begin
      error_cnt++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // A register read strobes rd; the data is there one edge later
  task automatic rw(input logic w, input logic [7:0] a, input logic [7:0] d);
    @(posedge ref_clk_i);
    req <= '{addr: a, wr: w, rd: ~w, wdata: d};
    @(posedge ref_clk_i);
    req <= '0;
    #1;
    v = rdata;
  endtask
  task automatic wait_intr();
    for (int n = 0; n < 200 && intr !== 1'b1; n++) @(posedge ref_clk_i);
    #1;
    chk({7'h0, intr}, 8'h01);
  endtask
  task automatic tend(input string s);
    $display("test %s finished", s);
  endtask
  task automatic finish_test();
    $display("comparisons %0d mismatches %0d", cmp_count, error_cnt);
    if (error_cnt == 0 && cmp_count > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask
  // ------------------------------------------------------------
  // Scenarios
  // ------------------------------------------------------------
  initial
  begin
    repeat (6) @(posedge ref_clk_i);
    rst_n_i <= 1'b1;
    foreach (ROWS[i])
    begin
      if (ROWS[i][24]) rw(1'b1, ROWS[i][23:16], ROWS[i][15:8]);
      rw(1'b0, ROWS[i][23:16], 8'h00);
      chk(v, ROWS[i][7:0]);
    end
    tend("registers");
    i_mst.start_c();
    rw(1'b0, ST, 8'h00);
    chk(v & 8'h08, 8'h08);
    i_mst.byte_x({8'ha4, 1'b1}, q);
    chk({7'h0, q[0]}, 8'h00);
    wait_intr();
    rw(1'b0, ST, 8'h00);
    chk(v & 8'h31, 8'h21);
    chk({6'h0, match_seen, scl_oe}, 8'h03);
    rw(1'b1, ST, 8'h00);
    rw(1'b0, DT, 8'h00);
    chk({7'h0, scl_oe}, 8'h00);
    i_mst.byte_x({8'h96, 1'b1}, q);
    wait_intr();
    rw(1'b1, ST, 8'h00);
    rw(1'b0, DT, 8'h00);
    chk(v, 8'h96);
    i_mst.stop_c();
    rw(1'b0, ST, 8'h00);
    chk(v & 8'h28, 8'h20);
    rw(1'b1, ST, 8'h00);
    tend("slave receive");
    match_seen = 1'b0;
    i_mst.start_c();
    i_mst.byte_x({8'h30, 1'b1}, q);
    repeat (4) @(posedge ref_clk_i);
    #1;
    chk({4'h0, q[0], match_seen, intr, scl_oe}, 8'h08);
    i_mst.stop_c();
    rw(1'b0, ST, 8'h00);
    chk(v & 8'h28, 8'h00);
    tend("address mismatch");
    i_mst.start_c();
    i_mst.byte_x({8'ha5, 1'b1}, q);
    chk({7'h0, q[0]}, 8'h00);
    wait_intr();
    chk({7'h0, txm}, 8'h01);
    rw(1'b1, ST, 8'h00);
    for (int k = 0; k < 2; k++)
    begin
      rw(1'b1, DT, TXB[k]);
      chk({7'h0, scl_oe}, 8'h00);
      i_mst.byte_x({8'hff, k[0]}, q);
      chk(q[8:1], TXB[k]);
      wait_intr();
      rw(1'b0, ST, 8'h00);
      chk(v & 8'h02, {6'h0, k[0], 1'b0});
      rw(1'b1, ST, 8'h00);
    end
    rw(1'b1, DT, 8'hff);
    i_mst.stop_c();
    rw(1'b0, AD, 8'h00);
    chk(v, 8'ha4);
    tend("slave transmit");
    // Master: address byte left unacknowledged, then a requested stop
    rw(1'b1, ST, 8'h00);
    rw(1'b1, DT, 8'h5a);
    @(posedge ref_clk_i);
    start_req <= 1'b1;
    @(posedge ref_clk_i);
    start_req <= 1'b0;
    wait_intr();
    chk(cap[8:1], 8'h5a);
    repeat (40) @(posedge ref_clk_i);
    rw(1'b0, ST, 8'h00);
    chk(v & 8'h3f, 8'h3a);
    chk({7'h0, scl_oe}, 8'h01);
    rw(1'b1, ST, 8'h00);
    @(posedge ref_clk_i);
    stop_req <= 1'b1;
    for (int n = 0; n < 100 && !done_seen; n++) @(posedge ref_clk_i);
    stop_req <= 1'b0;
    repeat (4) @(posedge ref_clk_i);
    rw(1'b0, ST, 8'h00);
    chk({6'h0, done_seen, v[3]}, 8'h02);
    tend("master");
    // Reset in mid-run brings every register back
    @(posedge ref_clk_i);
    rst_n_i <= 1'b0;
    repeat (3) @(posedge ref_clk_i);
    rst_n_i <= 1'b1;
    rw(1'b0, AD, 8'h00);
    chk(v, 8'h00);
    rw(1'b0, DT, 8'h00);
    chk(v, 8'h00);
    rw(1'b0, ST, 8'h00);
    chk(v, 8'h00);
    tend("reset");
    finish_test();
  end
  // The whole run needs under two thousand cycles
  initial
  begin
    repeat (20000) @(posedge ref_clk_i);
    error_cnt++;
    finish_test();
  end
endmodule
